/* File: logic/crs_pkg.sv */
// How it works
// RULE_01: Peripheral registers sit at data addresses F80H to FFFH of bank 15.
// RULE_02: Unbacked peripheral addresses store nothing; legal access width depends on address.
// RULE_03: Four banks of eight nibble general registers, each nibble reachable alone.
// RULE_04: Active register bank is register bank enable ANDed with bank select.
// RULE_05: BC, DE, HL, XA form byte pairs; DL, DE, HL also serve as pointers.
// RULE_06: General registers are plain data RAM, always reachable by memory access.
// RULE_07: A is the nibble accumulator, XA the byte accumulator, carry the bit one.
// RULE_08: Stack pointer is an 8-bit in-bank address of the RAM stack.
// RULE_09: Two-bit stack bank select picks stack bank 0 to 3.
// RULE_10: Stack pointer drops before each save write, rises after each restore read.
// RULE_11: Upper two bits of the stack bank select always read 00.
// RULE_12: Stack pointer written as a byte, bank select as a nibble; both readable.
// RULE_13: With stack pointer 00H the first save lands at nFFH of the bank.
// RULE_14: Stack addresses wrap within the selected bank.
// RULE_15: Stack pointer, bank select and carry are undefined after reset; the code loads 00H, 0 and 0 at reset.
// RULE_16: Status word sits at FB0H/FB1H; only the FB0H nibble is memory reachable.
// RULE_17: Calls push only bank enable flags; interrupts push the whole status word.
// RULE_18: Plain returns restore bank enable flags; interrupt return restores all, carry too; the code restores all but the skip flags.
// RULE_19: Add with carry and subtract with borrow leave their carry out in carry.
// RULE_20: Carry can be set, cleared, inverted; a test skips when carry is 1.
// RULE_21: Carry combined with a memory bit by AND, OR or XOR into carry.
// RULE_22: Carry copied into a memory bit, or a memory bit copied into carry.
// RULE_23: With register bank enable 0, bank 0 is the register bank.
// RULE_24: In a pair the first-named register is the upper nibble.
package crs_pkg;

    localparam logic [11:0] ADDR_STACK_POINTER = 12'hF80;
    localparam logic [11:0] ADDR_STACK_BANK    = 12'hF84;
    localparam logic [11:0] ADDR_PSW_LOW       = 12'hFB0;
    localparam logic [4:0]  PERIPH_PREFIX      = 5'h1F;

    // Not reset by the hardware in principle; a fixed value keeps simulation clean
    localparam logic [7:0]  STACK_POINTER_RESET = 8'h00;
    localparam logic [1:0]  STACK_BANK_RESET    = 2'h0;
    localparam logic        CARRY_RESET         = 1'b0;
    localparam logic [1:0]  REG_BANK_SEL_RESET  = 2'h0;
    localparam logic [1:0]  IST_RESET           = 2'h0;

    localparam int PSW_CARRY_POS = 7;
    localparam int PSW_SKIP_POS  = 4;
    localparam int PSW_IST_POS   = 2;
    localparam int PSW_MBE_POS   = 1;
    localparam int PSW_RBE_POS   = 0;

    // Register index inside a bank; low nibble of each pair at the even index
    localparam logic [2:0] REG_A = 3'h0;
    localparam logic [2:0] REG_X = 3'h1;
    localparam logic [2:0] REG_L = 3'h2;
    localparam logic [2:0] REG_H = 3'h3;
    localparam logic [2:0] REG_E = 3'h4;
    localparam logic [2:0] REG_D = 3'h5;
    localparam logic [2:0] REG_C = 3'h6;
    localparam logic [2:0] REG_B = 3'h7;

    localparam logic [2:0] PAIR_XA = 3'h0;
    localparam logic [2:0] PAIR_HL = 3'h1;
    localparam logic [2:0] PAIR_DE = 3'h2;
    localparam logic [2:0] PAIR_BC = 3'h3;
    localparam logic [2:0] PAIR_DL = 3'h4;

    typedef enum logic [4:0] {
        OP_NOP, OP_MEM_RD4, OP_MEM_WR4, OP_MEM_RD8, OP_MEM_WR8,
        OP_REG_RD, OP_REG_WR, OP_PAIR_RD, OP_PAIR_WR,
        OP_ADD_WITH_CARRY_OP, OP_SUBTRACT_WITH_BORROW_OP, OP_CY_SET, OP_CY_CLR, OP_CY_NOT, OP_CY_SKT,
        OP_BIT_AND, OP_BIT_OR, OP_BIT_XOR, OP_BIT_TO_MEM, OP_BIT_TO_CY,
        OP_PUSH8, OP_POP8, OP_CALL_SAVE, OP_INT_SAVE,
        OP_RET_RESTORE, OP_INTERRUPT_EXIT_RESTORE, OP_SEL_RB
    } crs_op_t;

    typedef struct packed {
        logic        valid;
        crs_op_t     op;
        logic [11:0] addr;
        logic [7:0]  wdata;
        logic [1:0]  bit_pos;
    } crs_cmd_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] rdata;
        logic       err;
        logic       skip;
    } crs_rsp_t;

    function automatic logic crs_is_data(input logic [11:0] a);
        return a[11:10] == 2'b00;
    endfunction

    function automatic logic [9:0] crs_reg_addr(input logic [1:0] bank, input logic [2:0] r);
        return {5'h00, bank, r};
    endfunction

    function automatic logic [9:0] crs_stack_addr(input logic [1:0] bank, input logic [7:0] off);
        return {bank, off};
    endfunction

endpackage

/* File: logic/crs_ram.sv */
`timescale 1ns/1ps
module crs_ram
    import crs_pkg::*;
(
    // Clock
    input  wire logic       clk,
    // Port a
    input  wire logic [9:0] a_addr,
    input  wire logic       a_we,
    input  wire logic [3:0] a_wd,
    output logic      [3:0] a_rd,
    // Port b
    input  wire logic [9:0] b_addr,
    input  wire logic       b_we,
    input  wire logic [3:0] b_wd,
    output logic      [3:0] b_rd
);
    // Banks 0 to 3 of static RAM; registers and stack share this array
    logic [3:0] mem [0:1023];

    assign a_rd = mem[a_addr];
    assign b_rd = mem[b_addr];

    // Callers never drive both ports to one address in a write cycle
    always_ff @(posedge clk) begin
        if (a_we) begin
            mem[a_addr] <= a_wd;
        end
        if (b_we) begin
            mem[b_addr] <= b_wd;
        end
    end
endmodule // crs_ram

/* File: logic/crs_carry.sv */
`timescale 1ns/1ps
module crs_carry
    import crs_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Operation, already gated by the caller
    input  crs_op_t         op,
    input  wire logic       bit_in,
    input  wire logic [3:0] acc,
    input  wire logic [3:0] opd,
    // Results
    output logic            carry_bit,
    output logic      [3:0] result
);
    logic       next_carry;
    logic [4:0] sum5;
    logic [4:0] diff5;

    assign sum5  = {1'b0, acc} + {1'b0, opd} + {4'h0, carry_bit};
    assign diff5 = {1'b0, acc} - {1'b0, opd} - {4'h0, carry_bit};

    always_comb begin
        next_carry = carry_bit;
        result     = acc;
        case (op)
            OP_ADD_WITH_CARRY_OP: begin
                next_carry = sum5[4]; // RULE_19
                result     = sum5[3:0];
            end
            OP_SUBTRACT_WITH_BORROW_OP: begin
                next_carry = diff5[4]; // RULE_19
                result     = diff5[3:0];
            end
            OP_CY_SET:       next_carry = 1'b1; // RULE_20
            OP_CY_CLR:       next_carry = 1'b0; // RULE_20
            OP_CY_NOT:       next_carry = ~carry_bit; // RULE_20
            OP_BIT_AND:      next_carry = carry_bit & bit_in; // RULE_21
            OP_BIT_OR:       next_carry = carry_bit | bit_in; // RULE_21
            OP_BIT_XOR:      next_carry = carry_bit ^ bit_in; // RULE_21
            OP_BIT_TO_CY:    next_carry = bit_in; // RULE_22
            OP_INTERRUPT_EXIT_RESTORE: next_carry = bit_in; // RULE_18
            default:         next_carry = carry_bit;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            carry_bit <= CARRY_RESET; // RULE_15
        end else begin
            carry_bit <= next_carry;
        end
    end
endmodule // crs_carry

/* File: logic/crs_top.sv */
`timescale 1ns/1ps
module crs_top
    import crs_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Flag values loaded at reset from the vector
    input  wire logic       reset_mbe,
    input  wire logic       reset_rbe,
    // Skip flags kept by the decoder, saved on interrupt
    input  wire logic [2:0] skip_flags,
    // Command and answer
    input  crs_cmd_t        cmd,
    output crs_rsp_t        rsp,
    // State
    output logic      [7:0] stack_pointer,
    output logic      [1:0] stack_bank_select,
    output logic            carry_bit,
    output logic            mem_bank_enable,
    output logic            reg_bank_enable,
    output logic      [1:0] reg_bank_select,
    output logic      [1:0] active_reg_bank,
    output logic      [1:0] int_status
);
    logic [9:0] a_addr;
    logic       a_we;
    logic [3:0] a_wd;
    logic [3:0] a_rd;
    logic [9:0] b_addr;
    logic       b_we;
    logic [3:0] b_wd;
    logic [3:0] b_rd;

    logic [7:0] next_sp;
    logic [1:0] next_sbs;
    logic       next_mbe;
    logic       next_rbe;
    logic [1:0] next_rbs;
    logic [1:0] next_ist;
    logic [7:0] next_rdata;
    logic       next_err;
    logic       next_skip;
    crs_op_t    carry_op;
    logic       carry_in;
    logic [3:0] alu_res;
    logic [7:0] push_byte;
    logic [7:0] pop_byte;
    logic [7:0] psw_byte;
    logic       periph;

    assign psw_byte = {carry_bit, skip_flags, int_status, mem_bank_enable, reg_bank_enable};
    assign pop_byte = {b_rd, a_rd};
    assign periph   = cmd.addr[11:7] == PERIPH_PREFIX; // RULE_01

    function automatic logic [2:0] pair_lo(input logic [2:0] p);
        return (p == PAIR_DL) ? REG_L : {p[1:0], 1'b0};
    endfunction

    function automatic logic [2:0] pair_hi(input logic [2:0] p);
        return (p == PAIR_DL) ? REG_D : {p[1:0], 1'b1};
    endfunction

    crs_ram u_ram (
        .clk    (clk),
        .a_addr (a_addr),
        .a_we   (a_we),
        .a_wd   (a_wd),
        .a_rd   (a_rd),
        .b_addr (b_addr),
        .b_we   (b_we),
        .b_wd   (b_wd),
        .b_rd   (b_rd)
    );

    crs_carry u_carry (
        .clk       (clk),
        .rst_n     (rst_n),
        .op        (carry_op),
        .bit_in    (carry_in),
        .acc       (a_rd),
        .opd       (cmd.wdata[3:0]),
        .carry_bit (carry_bit),
        .result    (alu_res)
    );

    always_comb begin
        a_addr     = cmd.addr[9:0];
        b_addr     = {cmd.addr[9:1], 1'b1};
        a_we       = 1'b0;
        b_we       = 1'b0;
        a_wd       = cmd.wdata[3:0];
        b_wd       = cmd.wdata[7:4];
        next_sp    = stack_pointer;
        next_sbs   = stack_bank_select;
        next_mbe   = mem_bank_enable;
        next_rbe   = reg_bank_enable;
        next_rbs   = reg_bank_select;
        next_ist   = int_status;
        next_rdata = 8'h00;
        next_err   = 1'b0;
        next_skip  = 1'b0;
        carry_in   = 1'b0;
        push_byte  = cmd.wdata;
        if (cmd.op == OP_CALL_SAVE) begin
            push_byte = {6'h00, mem_bank_enable, reg_bank_enable}; // RULE_17
        end else if (cmd.op == OP_INT_SAVE) begin
            push_byte = psw_byte; // RULE_17
        end
        if (cmd.valid) begin
            case (cmd.op)
                OP_MEM_RD4: begin
                    if (crs_is_data(cmd.addr)) begin
                        next_rdata = {4'h0, a_rd}; // RULE_06
                    end else if (cmd.addr == ADDR_STACK_BANK) begin
                        next_rdata = {6'h00, stack_bank_select}; // RULE_11 RULE_12
                    end else if (cmd.addr == ADDR_PSW_LOW) begin
                        next_rdata = {4'h0, int_status, mem_bank_enable, reg_bank_enable}; // RULE_16
                    end else begin
                        next_err = 1'b1; // RULE_02
                    end
                end
                OP_MEM_WR4: begin
                    if (crs_is_data(cmd.addr)) begin
                        a_we = 1'b1; // RULE_06
                    end else if (cmd.addr == ADDR_STACK_BANK) begin
                        next_sbs = cmd.wdata[1:0]; // RULE_11 RULE_12
                    end else if (cmd.addr == ADDR_PSW_LOW) begin
                        next_ist = cmd.wdata[3:2]; // RULE_16
                        next_mbe = cmd.wdata[PSW_MBE_POS];
                        next_rbe = cmd.wdata[PSW_RBE_POS];
                    end else begin
                        next_err = 1'b1; // RULE_02
                    end
                end
                OP_MEM_RD8: begin
                    a_addr = {cmd.addr[9:1], 1'b0};
                    if (cmd.addr[0]) begin
                        next_err = 1'b1;
                    end else if (crs_is_data(cmd.addr)) begin
                        next_rdata = pop_byte;
                    end else if (cmd.addr == ADDR_STACK_POINTER) begin
                        next_rdata = stack_pointer; // RULE_12
                    end else begin
                        next_err = 1'b1; // RULE_02
                    end
                end
                OP_MEM_WR8: begin
                    a_addr = {cmd.addr[9:1], 1'b0};
                    if (cmd.addr[0]) begin
                        next_err = 1'b1;
                    end else if (crs_is_data(cmd.addr)) begin
                        a_we = 1'b1;
                        b_we = 1'b1;
                    end else if (cmd.addr == ADDR_STACK_POINTER) begin
                        next_sp = cmd.wdata; // RULE_08 RULE_12
                    end else begin
                        next_err = 1'b1; // RULE_02
                    end
                end
                OP_REG_RD: begin
                    a_addr     = crs_reg_addr(active_reg_bank, cmd.addr[2:0]); // RULE_03
                    next_rdata = {4'h0, a_rd};
                end
                OP_REG_WR: begin
                    a_addr = crs_reg_addr(active_reg_bank, cmd.addr[2:0]); // RULE_03
                    a_we   = 1'b1;
                end
                OP_PAIR_RD: begin
                    a_addr = crs_reg_addr(active_reg_bank, pair_lo(cmd.addr[2:0])); // RULE_05
                    b_addr = crs_reg_addr(active_reg_bank, pair_hi(cmd.addr[2:0])); // RULE_24
                    next_err = cmd.addr[2:0] > PAIR_DL;
                    next_rdata = pop_byte;
                end
                OP_PAIR_WR: begin
                    a_addr = crs_reg_addr(active_reg_bank, pair_lo(cmd.addr[2:0])); // RULE_05
                    b_addr = crs_reg_addr(active_reg_bank, pair_hi(cmd.addr[2:0])); // RULE_24
                    next_err = cmd.addr[2:0] > PAIR_DL;
                    a_we = cmd.addr[2:0] <= PAIR_DL;
                    b_we = cmd.addr[2:0] <= PAIR_DL;
                end
                OP_ADD_WITH_CARRY_OP, OP_SUBTRACT_WITH_BORROW_OP: begin
                    a_addr     = crs_reg_addr(active_reg_bank, REG_A); // RULE_07
                    a_we       = 1'b1;
                    a_wd       = alu_res;
                    next_rdata = {4'h0, alu_res};
                end
                OP_CY_SKT: begin
                    next_skip = carry_bit; // RULE_20
                end
                OP_BIT_AND, OP_BIT_OR, OP_BIT_XOR, OP_BIT_TO_CY: begin
                    carry_in = a_rd[cmd.bit_pos]; // RULE_21 RULE_22
                    next_err = !crs_is_data(cmd.addr);
                end
                OP_BIT_TO_MEM: begin
                    a_wd = a_rd;
                    a_wd[cmd.bit_pos] = carry_bit; // RULE_22
                    a_we     = crs_is_data(cmd.addr);
                    next_err = !crs_is_data(cmd.addr);
                end
                OP_PUSH8, OP_CALL_SAVE, OP_INT_SAVE: begin
                    // Decrement first; the 8-bit offset wraps inside the bank
                    a_addr  = crs_stack_addr(stack_bank_select, stack_pointer - 8'h02); // RULE_10 RULE_14
                    b_addr  = crs_stack_addr(stack_bank_select, stack_pointer - 8'h01); // RULE_13 RULE_09
                    a_wd    = push_byte[3:0];
                    b_wd    = push_byte[7:4];
                    a_we    = 1'b1;
                    b_we    = 1'b1;
                    next_sp = stack_pointer - 8'h02; // RULE_10
                end
                OP_POP8, OP_RET_RESTORE, OP_INTERRUPT_EXIT_RESTORE: begin
                    a_addr     = crs_stack_addr(stack_bank_select, stack_pointer); // RULE_09 RULE_14
                    b_addr     = crs_stack_addr(stack_bank_select, stack_pointer + 8'h01);
                    next_rdata = pop_byte;
                    next_sp    = stack_pointer + 8'h02; // RULE_10
                    if (cmd.op != OP_POP8) begin
                        next_mbe = pop_byte[PSW_MBE_POS]; // RULE_18
                        next_rbe = pop_byte[PSW_RBE_POS]; // RULE_18
                    end
                    if (cmd.op == OP_INTERRUPT_EXIT_RESTORE) begin
                        next_ist = pop_byte[PSW_IST_POS +: 2]; // RULE_18
                        carry_in = pop_byte[PSW_CARRY_POS]; // RULE_18
                    end
                end
                OP_SEL_RB: begin
                    next_rbs = cmd.wdata[1:0];
                end
                default: begin
                    next_err = 1'b0;
                end
            endcase
        end
        if (periph && !crs_is_data(cmd.addr) && cmd.op == OP_MEM_RD4 && cmd.addr == ADDR_STACK_POINTER) begin
            next_err = 1'b1; // RULE_02
        end
    end

    // Carry sees only legal, valid operations so an error never disturbs it
    assign carry_op = (cmd.valid && !next_err) ? cmd.op : OP_NOP;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stack_pointer     <= STACK_POINTER_RESET; // RULE_15
            stack_bank_select <= STACK_BANK_RESET; // RULE_15
        end else begin
            stack_pointer     <= next_sp;
            stack_bank_select <= next_sbs;
        end
    end

    // Synchronous reset, so taking the vector flags here is a clocked capture
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mem_bank_enable <= reset_mbe;
            reg_bank_enable <= reset_rbe;
            reg_bank_select <= REG_BANK_SEL_RESET;
            active_reg_bank <= {2{reset_rbe}} & REG_BANK_SEL_RESET;
            int_status      <= IST_RESET;
        end else begin
            mem_bank_enable <= next_mbe;
            reg_bank_enable <= next_rbe;
            reg_bank_select <= next_rbs;
            active_reg_bank <= {2{next_rbe}} & next_rbs; // RULE_04 RULE_23
            int_status      <= next_ist;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rsp <= '0;
        end else begin
            rsp.valid <= cmd.valid;
            rsp.rdata <= next_rdata;
            rsp.err   <= next_err;
            rsp.skip  <= next_skip;
        end
    end

    AST_ACTIVE_BANK: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
        active_reg_bank == ({2{reg_bank_enable}} & reg_bank_select))
        else $error("active bank mismatch");
    AST_BANK0_WHEN_OFF: assert property (@(posedge clk) disable iff (!rst_n) // RULE_23
        !reg_bank_enable |-> active_reg_bank == 2'h0)
        else $error("bank not 0 with enable off");
    AST_PUSH_DEC: assert property (@(posedge clk) disable iff (!rst_n) // RULE_10
        cmd.valid && cmd.op == OP_PUSH8 |=> stack_pointer == $past(stack_pointer) - 8'h02)
        else $error("push did not drop pointer by two");
    AST_POP_INC: assert property (@(posedge clk) disable iff (!rst_n) // RULE_10
        cmd.valid && cmd.op == OP_POP8 |=> stack_pointer == $past(stack_pointer) + 8'h02)
        else $error("pop did not raise pointer by two");
    AST_SBS_UPPER: assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
        cmd.valid && cmd.op == OP_MEM_RD4 && cmd.addr == ADDR_STACK_BANK |=> rsp.rdata[7:2] == 6'h00)
        else $error("bank select upper bits not zero");
    AST_UNMAPPED: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
        cmd.valid && cmd.op == OP_MEM_RD4 && cmd.addr[11:10] != 2'b00 && !periph |=> rsp.err)
        else $error("unmapped access not refused");
    AST_CALL_KEEPS_CY: assert property (@(posedge clk) disable iff (!rst_n) // RULE_17
        cmd.valid && (cmd.op == OP_CALL_SAVE || cmd.op == OP_RET_RESTORE) |=> $stable(carry_bit))
        else $error("call or return touched carry");
    AST_CY_NOT: assert property (@(posedge clk) disable iff (!rst_n) // RULE_20
        cmd.valid && cmd.op == OP_CY_NOT |=> carry_bit != $past(carry_bit))
        else $error("carry not inverted");
    AST_SKT: assert property (@(posedge clk) disable iff (!rst_n) // RULE_20
        cmd.valid && cmd.op == OP_CY_SKT |=> rsp.skip == $past(carry_bit))
        else $error("skip does not follow carry");
    AST_SP_WRITE: assert property (@(posedge clk) disable iff (!rst_n) // RULE_12
        cmd.valid && cmd.op == OP_MEM_WR8 && cmd.addr == ADDR_STACK_POINTER |=> stack_pointer == $past(cmd.wdata))
        else $error("stack pointer write lost");

    COV_PUSH_POP: cover property (@(posedge clk) disable iff (!rst_n)
        cmd.valid && cmd.op == OP_PUSH8 ##1 cmd.valid && cmd.op == OP_POP8);
    COV_WRAP: cover property (@(posedge clk) disable iff (!rst_n)
        cmd.valid && cmd.op == OP_PUSH8 && stack_pointer == 8'h00);
    COV_INTERRUPT_EXIT: cover property (@(posedge clk) disable iff (!rst_n)
        cmd.valid && cmd.op == OP_INT_SAVE ##[1:20] cmd.valid && cmd.op == OP_INTERRUPT_EXIT_RESTORE);
endmodule // crs_top

/* File: sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import crs_pkg::*;
    logic       clk, rst_n, reset_mbe, reset_rbe, carry_bit, mem_bank_enable, reg_bank_enable, sk, er;
    logic [2:0] skip_flags;
    logic [1:0] stack_bank_select, reg_bank_select, active_reg_bank, int_status;
    logic [7:0] stack_pointer, rd;
    crs_cmd_t   cmd;
    crs_rsp_t   rsp;
    int         err_count, n_tests, a, d, c, m, r, i, k, stk[$];
    logic [11:0] bad [5] = '{12'hF81, 12'hFB1, 12'h400, 12'hF90, 12'hEFF};
    // Pair codes 0 to 4 are XA, HL, DE, BC, DL; the first-named register is the high nibble
    logic [2:0] hi_idx [5] = '{REG_X, REG_H, REG_D, REG_B, REG_D};
    logic [2:0] lo_idx [5] = '{REG_A, REG_L, REG_E, REG_C, REG_L};

    crs_top dut (
        .clk(clk), .rst_n(rst_n), .reset_mbe(reset_mbe), .reset_rbe(reset_rbe), .skip_flags(skip_flags),
        .cmd(cmd), .rsp(rsp), .stack_pointer(stack_pointer), .stack_bank_select(stack_bank_select),
        .carry_bit(carry_bit), .mem_bank_enable(mem_bank_enable), .reg_bank_enable(reg_bank_enable),
        .reg_bank_select(reg_bank_select), .active_reg_bank(active_reg_bank), .int_status(int_status)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Entered at a falling edge; the answer is registered, so it is settled one falling edge later
    // Valid stays high: the next call replaces the command before the next rising edge
    task automatic run(crs_op_t op, logic [11:0] ad = 12'h000, logic [7:0] wd = 8'h00, logic [1:0] bp = 2'h0);
        cmd = '{1'b1, op, ad, wd, bp};
        @(negedge clk);
        chk("rsp_valid", {7'h00, rsp.valid}, 8'h01);
        rd = rsp.rdata;
        er = rsp.err;
        sk = rsp.skip;
    endtask

    initial begin
        err_count = 0;
        n_tests = 0;
        void'($urandom(75));
        rst_n = 1'b0;
        reset_mbe = 1'b1;
        reset_rbe = 1'b0;
        skip_flags = 3'h5;
        cmd = '0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        run(OP_MEM_WR8, ADDR_STACK_POINTER, 8'h01);
        run(OP_MEM_RD8, ADDR_STACK_POINTER);
        chk("sp_read", rd, 8'h01);
        run(OP_MEM_WR4, ADDR_STACK_BANK, 8'h0E);
        run(OP_MEM_RD4, ADDR_STACK_BANK);
        chk("sbs_read", rd & 8'h0F, 8'h02);
        chk("sbs_state", {6'h00, stack_bank_select}, 8'h02);
        $display("test stack registers done");
        d = $urandom % 256;
        run(OP_PUSH8, 12'h000, d[7:0]);
        chk("sp_push", stack_pointer, 8'hFF);
        run(OP_MEM_RD4, 12'h200);
        chk("wrap_high", rd & 8'h0F, d[7:4]);
        run(OP_MEM_RD4, 12'h2FF);
        chk("wrap_low", rd & 8'h0F, d[3:0]);
        run(OP_POP8);
        chk("pop_data", rd, d[7:0]);
        chk("sp_pop", stack_pointer, 8'h01);
        run(OP_MEM_WR8, ADDR_STACK_POINTER, 8'h00);
        run(OP_PUSH8, 12'h000, 8'hA5);
        run(OP_MEM_RD4, 12'h2FF);
        chk("first_save", rd & 8'h0F, 8'h0A);
        for (i = 0; i < 4; i++) begin
            d = $urandom % 256;
            stk.push_back(d);
            run(OP_PUSH8, 12'h000, d[7:0]);
        end
        for (i = 0; i < 4; i++) begin
            run(OP_POP8);
            chk("lifo", rd, stk.pop_back());
        end
        $display("test stack wrap done");
        for (i = 0; i < 5; i++) begin
            run(OP_MEM_RD4, bad[i]);
            chk("refused", {7'h00, er}, 8'h01);
        end
        run(OP_MEM_WR8, 12'h001, 8'h33);
        chk("odd_pair", {7'h00, er}, 8'h01);
        $display("test refusals done");
        run(OP_SEL_RB, 12'h000, 8'h02);
        chk("bank_off", active_reg_bank, 8'h00);
        chk("rbs_state", {6'h00, reg_bank_select}, 8'h02);
        run(OP_MEM_WR4, ADDR_PSW_LOW, 8'h03);
        chk("bank_on", active_reg_bank, 8'h02);
        run(OP_MEM_RD4, ADDR_PSW_LOW);
        chk("psw_nibble", rd & 8'h0F, 8'h03);
        $display("test register banks done");
        for (i = 0; i < 5; i++) begin
            d = $urandom % 256;
            if (i == 0) r = d;
            run(OP_PAIR_WR, i[11:0], d[7:0]);
            run(OP_MEM_RD4, {9'h002, hi_idx[i]});
            chk("pair_high", rd, d[7:4]);
            run(OP_MEM_RD4, {9'h002, lo_idx[i]});
            chk("pair_low", rd, d[3:0]);
            run(OP_REG_RD, {9'h000, hi_idx[i]});
            chk("reg_read", rd, d[7:4]);
            run(OP_PAIR_RD, i[11:0]);
            chk("pair_read", rd, d[7:0]);
        end
        run(OP_MEM_RD8, 12'h010);
        chk("accum_pair", rd, r[7:0]);
        run(OP_PAIR_RD, 12'h005);
        chk("pair_refused", {7'h00, er}, 8'h01);
        run(OP_REG_WR, {9'h000, REG_A}, 8'h0C);
        run(OP_MEM_RD4, {9'h002, REG_A});
        chk("reg_write", rd, 8'h0C);
        $display("test register pairs done");
        for (i = 0; i < 8; i++) begin
            a = $urandom % 16;
            d = $urandom % 16;
            c = $urandom % 2;
            run(c ? OP_CY_SET : OP_CY_CLR);
            chk("carry_direct", carry_bit, c[7:0]);
            // Register A of bank 2 is reached as plain RAM
            run(OP_MEM_WR4, 12'h010, a[7:0]);
            run(i % 2 ? OP_SUBTRACT_WITH_BORROW_OP : OP_ADD_WITH_CARRY_OP, 12'h000, d[7:0]);
            r = i % 2 ? a - d - c : a + d + c;
            chk("arith", rd & 8'h0F, r & 15);
            chk("arith_carry", carry_bit, (r > 15 || r < 0) ? 8'h01 : 8'h00);
            c = (r > 15 || r < 0);
            run(OP_CY_SKT);
            chk("skip", sk, c[7:0]);
            run(OP_CY_NOT);
            chk("invert", carry_bit, c ? 8'h00 : 8'h01);
        end
        $display("test carry arithmetic done");
        m = $urandom % 16;
        run(OP_MEM_WR4, 12'h123, m[7:0]);
        for (i = 0; i < 12; i++) begin
            k = i % 3;
            c = $urandom % 2;
            run(c ? OP_CY_SET : OP_CY_CLR);
            run(k == 0 ? OP_BIT_AND : k == 1 ? OP_BIT_OR : OP_BIT_XOR, 12'h123, 8'h00, i[3:2]);
            r = m >> i[3:2] & 1;
            r = k == 0 ? c & r : k == 1 ? c | r : c ^ r;
            chk("bit_logic", carry_bit, r[7:0]);
        end
        run(OP_CY_SET);
        run(OP_BIT_TO_MEM, 12'h123, 8'h00, 2'h1);
        run(OP_BIT_TO_CY, 12'h123, 8'h00, 2'h3);
        chk("bit_load", carry_bit, m >> 3 & 1);
        run(OP_MEM_RD4, 12'h123);
        chk("bit_store", rd & 8'h0F, m | 2);
        $display("test bit operations done");
        run(OP_CY_SET);
        run(OP_INT_SAVE);
        run(OP_POP8);
        chk("int_frame", rd, 8'hD3);
        run(OP_CALL_SAVE);
        run(OP_POP8);
        chk("call_frame", rd, 8'h03);
        for (i = 0; i < 2; i++) begin
            run(OP_INT_SAVE);
            run(OP_CY_CLR);
            run(OP_MEM_WR4, ADDR_PSW_LOW, 8'h04);
            run(i ? OP_RET_RESTORE : OP_INTERRUPT_EXIT_RESTORE);
            chk("restore_carry", carry_bit, i ? 8'h00 : 8'h01);
            chk("restore_flags", {mem_bank_enable, reg_bank_enable}, 8'h03);
            chk("restore_ist", {6'h00, int_status}, i ? 8'h01 : 8'h00);
            run(OP_CY_SET);
        end
        $display("test status save done");
        wrap_up();
    end
endmodule // testbench
